// ===== rtl/svcr_regs.sv
// register bank of the second virtual channel: capability, control, status
// assumes a simple synchronous read/write port and a flow-control engine reporting link state
`include "svcr_consts.svh"
`default_nettype none
// Summary of operation
// R1 - With reject-snoop fixed at one, a transaction where no-snoop applies but is clear is an Unsupported Request.
// R2 - The port arbitration capability field reads 01h, fixed hardware arbitration only.
// R3 - Control bit 31 enables the channel when one, disables when zero, and resets to zero.
// R4 - The identifier at 26:24 resets to one, must be non-zero, and cannot change while enabled.
// R5 - Software programs the arbitration select only to a value matching a set capability bit; it resets to zero.
// R6 - Each set map bit routes the traffic class of that position to this channel; the map resets to zero.
// R7 - Traffic class zero always goes to the first channel, so map bit 0 is read-only zero.
// R8 - Software quiesces traffic of a class before removing it from an enabled channel's map.
// R9 - Negotiation pending reads one while initializing or disabling, zero once done, and resets to one.
// R10 - Pending is set on reset, while the channel is disabled, and while the link is down.
// R11 - Pending clears when the link leaves the second flow-control initialization state successfully.
// R12 - Reserved and read-only bits return fixed values and ignore writes.
// R13 - While enabled only mapped classes use the channel and the identifier stays stable.
module svcr_regs
  import svcr_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic CLK_EN,
  input wire logic [ADDR_W-1:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [3:0] REG_BE,
  input wire logic [31:0] REG_WDATA,
  input wire logic LINK_UP,
  input wire logic FC_INIT2_DONE,
  input wire logic [2:0] TLP_TC,
  input wire logic TLP_SNOOP_APPLIES,
  input wire logic TLP_NO_SNOOP,
  output logic [31:0] REG_RDATA,
  output logic REG_RVALID,
  output logic CHAN_ENABLE,
  output logic [2:0] CHAN_ID,
  output logic [2:0] ARB_SELECT,
  output logic [7:0] TC_MAP,
  output logic TC_HIT,
  output logic TLP_REJECT_UR
);
  logic enable_reg;
  logic [2:0] id_reg;
  logic [2:0] sel_reg;
  logic [7:1] map_reg;
  svcr_neg_t neg_reg;
  svcr_neg_t neg_next;
  logic pending;
  logic hit;
  logic reject;
  logic [31:0] cap_word;
  logic [31:0] ctl_word;
  logic [31:0] sts_word;
  logic [31:0] rd_next;
  logic wr_ctl;
  logic wr_lane3;
  logic wr_lane2;
  logic wr_lane0;
  logic id_wr_ok;

  // fixed capability and live control/status images; reserved bits are constant zero
  always_comb begin
    cap_word = `SVCR_CAP_RESET; // R2 R12
    cap_word[`SVCR_CAP_REJSN_BIT] = 1'b1; // R1
    ctl_word = 32'h0000_0000;
    ctl_word[`SVCR_CTL_EN_BIT] = enable_reg;
    ctl_word[`SVCR_CTL_ID_HI:`SVCR_CTL_ID_LO] = id_reg;
    ctl_word[`SVCR_CTL_SEL_HI:`SVCR_CTL_SEL_LO] = sel_reg;
    ctl_word[`SVCR_CTL_MAP_HI:`SVCR_CTL_MAP_LO] = map_reg; // R7 bit 0 stays zero
    sts_word = 32'h0000_0000;
    sts_word[`SVCR_STS_PEND_BIT] = pending; // R9
  end

  assign wr_ctl = REG_WR && (REG_ADDR == ADDR_W'(`SVCR_OFS_CTL));

  // lane strobes gated by the clock enable so a frozen bank takes nothing
  assign wr_lane3 = CLK_EN && wr_ctl && REG_BE[3];
  assign wr_lane2 = CLK_EN && wr_ctl && REG_BE[2];
  assign wr_lane0 = CLK_EN && wr_ctl && REG_BE[0];
  // old enable decides, so enable and id written together while off both take
  assign id_wr_ok = wr_lane3 && !enable_reg && (REG_WDATA[`SVCR_CTL_ID_HI:`SVCR_CTL_ID_LO] != 3'h0); // R4

  // enable bit, byte lane 3
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      enable_reg <= 1'b0;
    end else if (wr_lane3) begin
      enable_reg <= REG_WDATA[`SVCR_CTL_EN_BIT]; // R3
    end
  end

  // identifier: frozen while enabled, zero writes dropped since zero is illegal
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      id_reg <= `SVCR_ID_RESET;
    end else if (id_wr_ok) begin
      id_reg <= REG_WDATA[`SVCR_CTL_ID_HI:`SVCR_CTL_ID_LO]; // R4 R13
    end
  end

  // arbitration select, byte lane 2; value checking is software's job
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      sel_reg <= 3'h0;
    end else if (wr_lane2) begin
      sel_reg <= REG_WDATA[`SVCR_CTL_SEL_HI:`SVCR_CTL_SEL_LO]; // R5
    end
  end

  // class map, byte lane 0; bit 0 has no storage at all
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      map_reg <= 7'h00;
    end else if (wr_lane0) begin
      map_reg <= REG_WDATA[`SVCR_CTL_MAP_HI:`SVCR_CTL_MAP_LO]; // R6 R7 R8
    end
  end

  // negotiation tracker: pending unless enabled, link up and init2 exited
  always_comb begin
    neg_next = neg_reg;
    unique case (neg_reg)
      SVCR_NEG_PENDING: begin
        if (enable_reg && LINK_UP) begin
          neg_next = SVCR_NEG_INIT;
        end
      end
      SVCR_NEG_INIT: begin
        if (!enable_reg || !LINK_UP) begin
          neg_next = SVCR_NEG_PENDING; // R10
        end else if (FC_INIT2_DONE) begin
          neg_next = SVCR_NEG_DONE; // R11
        end
      end
      SVCR_NEG_DONE: begin
        if (!enable_reg || !LINK_UP) begin
          neg_next = SVCR_NEG_PENDING; // R10
        end
      end
      default: begin
        neg_next = SVCR_NEG_PENDING;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      neg_reg <= SVCR_NEG_PENDING; // R9 R10
    end else if (CLK_EN) begin
      neg_reg <= neg_next;
    end
  end

  assign pending = (neg_reg != SVCR_NEG_DONE);

  // read mux; unmapped addresses read zero
  always_comb begin
    unique case (REG_ADDR)
      ADDR_W'(`SVCR_OFS_CAP): rd_next = cap_word;
      ADDR_W'(`SVCR_OFS_CTL): rd_next = ctl_word;
      ADDR_W'(`SVCR_OFS_STS): rd_next = sts_word; // R12
      default: rd_next = 32'h0000_0000;
    endcase
  end

  // read valid pulse, one cycle after the strobe
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      REG_RVALID <= 1'b0;
    end else if (CLK_EN) begin
      REG_RVALID <= REG_RD;
    end
  end

  // read data held until the next read, so a slow master may still pick it up
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      REG_RDATA <= 32'h0000_0000;
    end else if (CLK_EN && REG_RD) begin
      REG_RDATA <= rd_next;
    end
  end

  // per-transaction check; only mapped classes pass once negotiated
  svcr_tc_check u_check (
    .tc(TLP_TC),
    .snoop_applies(TLP_SNOOP_APPLIES),
    .no_snoop(TLP_NO_SNOOP),
    .tc_map({map_reg, 1'b0}),
    .enable(enable_reg && !pending),
    .map_hit(hit),
    .reject_ur(reject)
  );

  // registered copies of the control fields so every output comes straight from a flop
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      CHAN_ENABLE <= 1'b0;
      CHAN_ID <= `SVCR_ID_RESET;
      ARB_SELECT <= 3'h0;
      TC_MAP <= 8'h00;
    end else if (CLK_EN) begin
      CHAN_ENABLE <= enable_reg; // R3
      CHAN_ID <= id_reg; // R13
      ARB_SELECT <= sel_reg;
      TC_MAP <= {map_reg, 1'b0}; // R7
    end
  end

  // transaction verdicts, one cycle after class and attributes arrive
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      TC_HIT <= 1'b0;
      TLP_REJECT_UR <= 1'b0;
    end else if (CLK_EN) begin
      TC_HIT <= hit; // R6 R13
      TLP_REJECT_UR <= reject; // R1
    end
  end
endmodule // svcr_regs
`default_nettype wire

// ===== rtl/svcr_consts.svh
// constants for the second virtual channel register bank
// assumes byte addresses within the link register base region
`ifndef SVCR_CONSTS_SVH
`define SVCR_CONSTS_SVH
`define SVCR_OFS_CAP 8'h1C
`define SVCR_OFS_CTL 8'h20
`define SVCR_OFS_STS 8'h26
`define SVCR_CAP_RESET 32'h0000_8001
`define SVCR_CTL_RESET 32'h0100_0000
`define SVCR_STS_RESET 16'h0002
`define SVCR_CAP_REJSN_BIT 15
`define SVCR_CTL_EN_BIT 31
`define SVCR_CTL_ID_HI 26
`define SVCR_CTL_ID_LO 24
`define SVCR_CTL_SEL_HI 19
`define SVCR_CTL_SEL_LO 17
`define SVCR_CTL_MAP_HI 7
`define SVCR_CTL_MAP_LO 1
`define SVCR_STS_PEND_BIT 1
`define SVCR_ARB_CAP 8'h01
`define SVCR_ID_RESET 3'h1
`endif

// ===== rtl/svcr_pkg.sv
// types for the second virtual channel register bank
// assumes svcr_consts.svh is on the include path
`default_nettype none
package svcr_pkg;
  typedef enum logic [1:0] {
    SVCR_NEG_PENDING = 2'b00,
    SVCR_NEG_INIT = 2'b01,
    SVCR_NEG_DONE = 2'b10
  } svcr_neg_t;
endpackage
`default_nettype wire

// ===== rtl/svcr_tc_check.sv
// per-transaction admission check for the second channel
// assumes tc and attribute inputs are synchronous to the clock
`include "svcr_consts.svh"
`default_nettype none
module svcr_tc_check (
  input wire logic [2:0] tc,
  input wire logic snoop_applies,
  input wire logic no_snoop,
  input wire logic [7:0] tc_map,
  input wire logic enable,
  output logic map_hit,
  output logic reject_ur
);
  // class zero never hits: bit 0 of the map is held zero
  always_comb begin
    map_hit = enable & tc_map[tc]; // R6 R13
    reject_ur = map_hit & snoop_applies & ~no_snoop; // R1
  end
endmodule // svcr_tc_check
`default_nettype wire

// ===== testbench/svcr_regs_asserts.sv
// checker for the second channel register bank
// assumes it is bound onto svcr_regs
`default_nettype none
module svcr_regs_asserts (
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic CLK_EN,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic TC_HIT,
  input wire logic TLP_REJECT_UR,
  input wire logic CHAN_ENABLE,
  input wire logic TLP_SNOOP_APPLIES,
  input wire logic TLP_NO_SNOOP,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] TC_MAP,
  input wire logic [3:0] REG_BE,
  input wire logic [31:0] REG_WDATA,
  input wire logic [31:0] REG_RDATA,
  input wire logic [2:0] CHAN_ID
);
  timeunit 1ns;
  timeprecision 1ns;
  logic rd_go;
  logic wr_ctl;
  logic wr_en_bit;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  // strobes only count when the clock enable lets the bank take them
  assign rd_go = REG_RD && CLK_EN;
  assign wr_ctl = REG_WR && CLK_EN && REG_ADDR == 8'h20 && REG_BE[3];
  assign wr_en_bit = REG_WDATA[31];
  property p_cap; rd_go && REG_ADDR == 8'h1C |=> REG_RDATA == 32'h0000_8001; endproperty
  a_cap: assert property (p_cap) else $error("capability value");
  property p_sts; rd_go && REG_ADDR == 8'h26 |=> REG_RDATA[31:2] == 30'h0 && !REG_RDATA[0]; endproperty
  a_sts: assert property (p_sts) else $error("status reserved bits");
  property p_pend; rd_go && REG_ADDR == 8'h26 && !CHAN_ENABLE && !$past(CHAN_ENABLE) |=> REG_RDATA[1]; endproperty
  a_pend: assert property (p_pend) else $error("pending clear while off");
  property p_map0; !TC_MAP[0]; endproperty
  a_map0: assert property (p_map0) else $error("class zero mapped");
  property p_idnz; CHAN_ID != 3'h0; endproperty
  a_idnz: assert property (p_idnz) else $error("zero identifier");
  property p_idlock; CHAN_ENABLE && $past(CHAN_ENABLE) |-> $stable(CHAN_ID); endproperty
  a_idlock: assert property (p_idlock) else $error("identifier moved");
  property p_ur;
    $past(CLK_EN) && TC_HIT |-> TLP_REJECT_UR == ($past(TLP_SNOOP_APPLIES) && !$past(TLP_NO_SNOOP));
  endproperty
  a_ur: assert property (p_ur) else $error("reject mismatch");
  property p_en; wr_ctl ##1 CLK_EN |=> CHAN_ENABLE == $past(wr_en_bit, 2); endproperty
  a_en: assert property (p_en) else $error("enable mirror");
  c_hit: cover property (TC_HIT);
  c_ur: cover property (TLP_REJECT_UR);
  c_lock: cover property (CHAN_ENABLE && wr_ctl);
endmodule // svcr_regs_asserts
bind svcr_regs svcr_regs_asserts u_svcr_regs_asserts (
  .SYS_CLK(SYS_CLK),
  .RESET(RESET),
  .CLK_EN(CLK_EN),
  .REG_WR(REG_WR),
  .REG_RD(REG_RD),
  .TC_HIT(TC_HIT),
  .TLP_REJECT_UR(TLP_REJECT_UR),
  .CHAN_ENABLE(CHAN_ENABLE),
  .TLP_SNOOP_APPLIES(TLP_SNOOP_APPLIES),
  .TLP_NO_SNOOP(TLP_NO_SNOOP),
  .REG_ADDR(REG_ADDR),
  .TC_MAP(TC_MAP),
  .REG_BE(REG_BE),
  .REG_WDATA(REG_WDATA),
  .REG_RDATA(REG_RDATA),
  .CHAN_ID(CHAN_ID)
);
`default_nettype wire

// ===== testbench/svcr_peer.sv
// link peer model: link state and flow-control init completion
// assumes the bank's enable mirror and a bench link request
`default_nettype none
module svcr_peer #(
  parameter int LAT = 3
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic en,
  input wire logic up,
  output logic link_up,
  output logic init_done
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_reg;
  assign link_up = up;
  // init restarts whenever the channel or link drops; no partial credit kept
  always_ff @(posedge clk) begin
    if (rst || !en || !up) cnt_reg <= 4'h0;
    else if (cnt_reg != LAT[3:0]) cnt_reg <= cnt_reg + 4'h1;
  end
  assign init_done = cnt_reg == LAT[3:0];
endmodule // svcr_peer
`default_nettype wire

// ===== testbench/svcr_regs_tb.sv
// self-checking bench for the second channel register bank
// assumes bank, checker and peer model are compiled first
`default_nettype none
module svcr_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic SYS_CLK = 0, RESET = 1, CLK_EN = 1, REG_WR = 0, REG_RD = 0, up = 0;
  logic TLP_SNOOP_APPLIES = 0, TLP_NO_SNOOP = 0, REG_RVALID, CHAN_ENABLE, TC_HIT;
  logic TLP_REJECT_UR, LINK_UP, FC_INIT2_DONE;
  logic [7:0] REG_ADDR = 8'h00, TC_MAP;
  logic [3:0] REG_BE = 4'hF;
  logic [31:0] REG_WDATA = 32'h0000_0000, REG_RDATA;
  logic [2:0] TLP_TC = 3'h0, CHAN_ID, ARB_SELECT;
  int bad_count = 0, checks = 0;
  initial forever #20 SYS_CLK = ~SYS_CLK;
  svcr_regs u_svcr_regs (
    .SYS_CLK(SYS_CLK),
    .RESET(RESET),
    .CLK_EN(CLK_EN),
    .REG_ADDR(REG_ADDR),
    .REG_WR(REG_WR),
    .REG_RD(REG_RD),
    .REG_BE(REG_BE),
    .REG_WDATA(REG_WDATA),
    .LINK_UP(LINK_UP),
    .FC_INIT2_DONE(FC_INIT2_DONE),
    .TLP_TC(TLP_TC),
    .TLP_SNOOP_APPLIES(TLP_SNOOP_APPLIES),
    .TLP_NO_SNOOP(TLP_NO_SNOOP),
    .REG_RDATA(REG_RDATA),
    .REG_RVALID(REG_RVALID),
    .CHAN_ENABLE(CHAN_ENABLE),
    .CHAN_ID(CHAN_ID),
    .ARB_SELECT(ARB_SELECT),
    .TC_MAP(TC_MAP),
    .TC_HIT(TC_HIT),
    .TLP_REJECT_UR(TLP_REJECT_UR)
  );
  svcr_peer u_svcr_peer (.clk(SYS_CLK), .rst(RESET), .en(CHAN_ENABLE), .up(up), .link_up(LINK_UP),
    .init_done(FC_INIT2_DONE));
  task automatic chk(input logic [31:0] g, e);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  // mirrored control outputs: enable, id, select, map
  task automatic chk_out(input logic [14:0] e);
    checks++;
    if ({CHAN_ENABLE, CHAN_ID, ARB_SELECT, TC_MAP} !== e) begin
      bad_count++;
      $display("[FAIL] %0t outputs %h want %h", $time, {CHAN_ENABLE, CHAN_ID, ARB_SELECT, TC_MAP}, e);
    end
  endtask
  // one-cycle strobes, driven just after the edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge SYS_CLK) #1;
    REG_ADDR = a;
    REG_WDATA = d;
    REG_WR = 1;
    @(posedge SYS_CLK) #1;
    REG_WR = 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge SYS_CLK) #1;
    REG_ADDR = a;
    REG_RD = 1;
    @(posedge SYS_CLK) #1;
    REG_RD = 0;
    chk(REG_RVALID === 1'b1 ? REG_RDATA : ~e, e);
  endtask
  // hit and reject come out one edge after the inputs; two edges leaves margin
  task automatic tlp(input logic [2:0] c, input logic s, n, input logic [31:0] e);
    TLP_TC = c;
    TLP_SNOOP_APPLIES = s;
    TLP_NO_SNOOP = n;
    repeat (2) @(posedge SYS_CLK);
    #1 chk({30'h0, TC_HIT, TLP_REJECT_UR}, e);
  endtask
  task automatic report_and_stop;
    if (bad_count == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #100000;
    bad_count++;
    report_and_stop;
  end
  initial begin
    repeat (8) @(posedge SYS_CLK);
    #1 RESET = 0;
    rd(8'h1C, 32'h0000_8001);
    rd(8'h20, 32'h0100_0000);
    rd(8'h26, 32'h0000_0002);
    chk_out({1'h0, 3'h1, 3'h0, 8'h00});
    wr(8'h1C, 32'hFFFF_FFFF);
    wr(8'h26, 32'hFFFF_FFFF);
    rd(8'h1C, 32'h0000_8001);
    wr(8'h20, 32'h7FF3_FFFF);
    rd(8'h20, 32'h0702_00FE);
    wr(8'h20, 32'h0002_00FE);
    rd(8'h20, 32'h0702_00FE);
    up = 1;
    wr(8'h20, 32'h8202_0004);
    repeat (12) @(posedge SYS_CLK);
    rd(8'h26, 32'h0000_0000);
    wr(8'h20, 32'h8502_0004);
    rd(8'h20, 32'h8202_0004);
    chk_out({1'h1, 3'h2, 3'h1, 8'h04});
    tlp(3'h2, 1, 0, 32'h3);
    tlp(3'h2, 1, 1, 32'h2);
    tlp(3'h2, 0, 0, 32'h2);
    tlp(3'h3, 1, 0, 32'h0);
    tlp(3'h0, 1, 0, 32'h0);
    wr(8'h20, 32'h8202_0088);
    tlp(3'h7, 1, 1, 32'h2);
    tlp(3'h3, 1, 0, 32'h3);
    up = 0;
    rd(8'h26, 32'h0000_0002);
    tlp(3'h7, 1, 1, 32'h0);
    CLK_EN = 0;
    wr(8'h20, 32'h0202_0088);
    CLK_EN = 1;
    rd(8'h20, 32'h8202_0088);
    chk_out({1'h1, 3'h2, 3'h1, 8'h88});
    wr(8'h20, 32'h0202_0088);
    rd(8'h20, 32'h0202_0088);
    rd(8'h26, 32'h0000_0002);
    REG_BE = 4'h1;
    wr(8'h20, 32'h8507_0006);
    REG_BE = 4'hF;
    rd(8'h20, 32'h0202_0006);
    chk_out({1'h0, 3'h2, 3'h1, 8'h06});
    rd(8'h40, 32'h0000_0000);
    report_and_stop;
  end
endmodule // svcr_regs_tb
`default_nettype wire
